// ---- pkg/sac_defs.vh ----
// Register map, field positions and constants of the serial CRC and audio control block
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
`define SAC_OFS_CTRL      12'h000
`define SAC_OFS_POLY      12'h010
`define SAC_OFS_RXCRC     12'h014
`define SAC_OFS_TXCRC     12'h018
`define SAC_OFS_AUDIO     12'h01c
`define SAC_OFS_STAT      12'h024
`define SAC_OFS_RXDATA    12'h028
`define SAC_CTRL_CRC_CHECK_ENABLE    0
`define SAC_CTRL_LSBF     1
`define SAC_CTRL_FRM16    2
`define SAC_CTRL_PRST     3
`define SAC_CTRL_SPIEN    4
`define SAC_CTRL_MASK     32'h0000001f
`define SAC_POLY_RST      16'h0007
`define SAC_AUD_MASK      32'h00000fbf
`define SAC_AUD_SEL       11
`define SAC_AUD_EN        10
`define SAC_AUD_OPM_HI    9
`define SAC_AUD_OPM_LO    8
`define SAC_AUD_PCMS      7
`define SAC_AUD_STD_HI    5
`define SAC_AUD_STD_LO    4
`define SAC_AUD_IDLE_CLOCK_LEVEL      3
`define SAC_AUD_DTL_HI    2
`define SAC_AUD_DTL_LO    1
`define SAC_AUD_CHL       0
`define SAC_OPM_STX       2'h0
`define SAC_OPM_SRX       2'h1
`define SAC_OPM_MTX       2'h2
`define SAC_OPM_MRX       2'h3
`define SAC_STD_PHIL      2'h0
`define SAC_STD_MSBJ      2'h1
`define SAC_STD_LSBJ      2'h2
`define SAC_STD_PCM       2'h3
`define SAC_DTL_16        2'h0
`define SAC_DTL_24        2'h1
`define SAC_DTL_32        2'h2
`define SAC_FIFO_DEPTH    16
`define SAC_FIFO_AW       4
`endif

// ---- hdl/sac_fifo.v ----
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sac_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage array
    reg [AW:0]      wp_ff;            // Write pointer with wrap bit
    reg [AW:0]      rp_ff;            // Read pointer with wrap bit
    wire            full;
    wire            empty;
    assign full      = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign empty     = (wp_ff == rp_ff);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rp_ff[AW-1:0]];
    // Array write, no reset needed on data
    always @(posedge clk) begin
        if (ce && in_valid && !full && !flush) begin
            mem[wp_ff[AW-1:0]] <= in_data;
        end
    end
    // Pointers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (flush) begin
                wp_ff <= {(AW+1){1'b0}};
                rp_ff <= {(AW+1){1'b0}};
            end else begin
                if (in_valid && !full) begin
                    wp_ff <= wp_ff + 1'b1;
                end
                if (out_ready && !empty) begin
                    rp_ff <= rp_ff + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/sac_top.v ----
// Serial port CRC accumulators, audio control register, AHB-Lite slave and receive shifter
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.vh"
module sac_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        peripheral_reset_bit,
    input  wire        audio_bit_clock,
    input  wire        link_sd_in,
    input  wire        link_ws_in,
    input  wire        tx_bit_valid,
    input  wire        tx_bit_value,
    input  wire        tx_frame_busy,
    output reg         sd_out_ff,
    output reg         audio_ck_out_ff,
    output reg         audio_ck_oe_ff,
    output reg         ws_oe_ff,
    output reg         sd_oe_ff
);
    reg  [31:0] ctrl_ff;         // Main control: CRC enable, bit order, frame size, reset, enable
    reg  [15:0] poly_ff;         // CRC polynomial
    reg  [15:0] rx_crc_value;    // Receive CRC accumulator
    reg  [15:0] tx_crc_value;    // Transmit CRC accumulator
    reg  [11:0] aud_ff;          // Audio port control, only mapped bits held
    reg  [31:0] hrdata_ff;       // Read data register
    reg         ap_wr_ff;        // Pending write data phase
    reg  [11:0] ap_addr_ff;      // Latched address
    reg  [2:0]  ck_sync_ff;      // Bit clock synchroniser plus edge history
    reg  [1:0]  sd_sync_ff;      // Serial data synchroniser
    reg  [1:0]  ws_sync_ff;      // Word select synchroniser
    reg         ws_d_ff;         // Previous synchronised word select
    reg  [15:0] rx_sh_ff;        // Receive shift register
    reg  [4:0]  rx_cnt_ff;       // Received bits in frame
    reg         rx_busy_ff;      // Receive frame in progress
    wire        crc_check_enable;
    wire        lsb_first_select;
    wire        frame16;
    wire        audio_mode_select;
    wire        audio_port_enable;
    wire [1:0]  audio_operation_mode;
    wire        pcm_sync_length;
    wire [1:0]  audio_standard_select;
    wire        idle_clock_level;
    wire [1:0]  sample_data_length;
    wire        channel_slot_length;
    wire        aud_active;      // Audio port really running
    wire        port_enable;     // Serial engine running in either mode
    wire        is_rx_mode;
    wire        is_master;
    wire        ck_rise;         // Sampling edge of the link clock
    wire        transfer_ongoing_flag;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire        fifo_pop;
    wire        fifo_push;
    wire        rx_done;
    wire        rx_start_cond;   // Framing says a new frame may begin here
    wire        rx_start;        // First bit of a frame is being taken
    wire [15:0] rx_next;         // Shifter value once the current bit is in
    wire [31:0] aud_wr_data;     // Bus word with reserved audio bits cleared
    wire        ap_take;
    wire        wr_ctrl;
    wire        crc_clr;
    wire [4:0]  frame_bits;
    reg  [31:0] rd_mux;
    // Field decode
    assign crc_check_enable      = ctrl_ff[`SAC_CTRL_CRC_CHECK_ENABLE];
    assign lsb_first_select      = ctrl_ff[`SAC_CTRL_LSBF];
    assign frame16               = ctrl_ff[`SAC_CTRL_FRM16];
    assign audio_mode_select     = aud_ff[`SAC_AUD_SEL];
    assign audio_port_enable     = aud_ff[`SAC_AUD_EN];
    assign audio_operation_mode  = aud_ff[`SAC_AUD_OPM_HI:`SAC_AUD_OPM_LO];
    assign pcm_sync_length       = aud_ff[`SAC_AUD_PCMS];
    assign audio_standard_select = aud_ff[`SAC_AUD_STD_HI:`SAC_AUD_STD_LO];
    assign idle_clock_level      = aud_ff[`SAC_AUD_IDLE_CLOCK_LEVEL];
    assign sample_data_length    = aud_ff[`SAC_AUD_DTL_HI:`SAC_AUD_DTL_LO];
    assign channel_slot_length   = aud_ff[`SAC_AUD_CHL];
    // Audio fields only count in audio mode
    assign aud_active  = audio_mode_select & audio_port_enable;
    assign port_enable = audio_mode_select ? aud_active : ctrl_ff[`SAC_CTRL_SPIEN];
    assign is_master   = aud_active & audio_operation_mode[1];
    assign is_rx_mode  = audio_mode_select ? audio_operation_mode[0] : 1'b1;
    // Frame length: SPI by frame size, audio by sample length
    // Longer audio samples keep only their last 16 bits in the shifter
    assign frame_bits = !audio_mode_select ? (frame16 ? 5'h0f : 5'h07) :
                        (sample_data_length == `SAC_DTL_16) ? 5'h0f :
                        (sample_data_length == `SAC_DTL_24) ? 5'h17 : 5'h1f;
    // CRC step over one bit, width 8 or 16
    function [15:0] sac_crc_step;
        input [15:0] crc;
        input [15:0] poly;
        input        bitv;
        input        wide;
        reg          fb;
        begin
            fb = bitv ^ (wide ? crc[15] : crc[7]);
            sac_crc_step = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
            if (!wide) begin
                sac_crc_step = {8'h00, sac_crc_step[7:0]};
            end
        end
    endfunction
    // Link synchronisers; first stage only feeds the second
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_sync_ff <= 3'h0;
            sd_sync_ff <= 2'h0;
            ws_sync_ff <= 2'h0;
            ws_d_ff    <= 1'b0;
        end else if (ce) begin
            ck_sync_ff <= {ck_sync_ff[1:0], audio_bit_clock};
            sd_sync_ff <= {sd_sync_ff[0], link_sd_in};
            ws_sync_ff <= {ws_sync_ff[0], link_ws_in};
            ws_d_ff    <= ws_sync_ff[1];
        end
    end
    // Data sampled on rising edge, or falling edge when idle level is high and the audio port is active
    assign ck_rise = (ck_sync_ff[2] != ck_sync_ff[1]) &&
                     (ck_sync_ff[1] == ~(aud_active & idle_clock_level));
    // Frame start: any sampled edge in SPI, word select change or long PCM sync in audio
    assign rx_start_cond = !audio_mode_select || (ws_sync_ff[1] != ws_d_ff) ||
                           (audio_standard_select == `SAC_STD_PCM && pcm_sync_length);
    // A full FIFO holds the start off, so no frame is half captured
    assign rx_start = ck_rise && !rx_busy_ff && rx_start_cond && fifo_in_ready &&
                      port_enable && is_rx_mode && !peripheral_reset_bit;
    // LSB first drops each bit at its own position so short frames stay right-aligned
    assign rx_next = lsb_first_select ?
                     ((rx_sh_ff & ~(16'h0001 << rx_cnt_ff[3:0])) | ({15'h0000, sd_sync_ff[1]} << rx_cnt_ff[3:0])) :
                     {rx_sh_ff[14:0], sd_sync_ff[1]};
    assign rx_done   = rx_busy_ff && ck_rise && (rx_cnt_ff == frame_bits);
    // The last bit lands in the same edge, so the FIFO takes the shifted value
    assign fifo_push = rx_done;
    // Receive shifter: starts on word select change or long PCM sync (audio) or first edge (SPI)
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sh_ff   <= 16'h0000;
            rx_cnt_ff  <= 5'h00;
            rx_busy_ff <= 1'b0;
        end else if (ce) begin
            if (!port_enable || !is_rx_mode || peripheral_reset_bit) begin
                rx_busy_ff <= 1'b0;
                rx_cnt_ff  <= 5'h00;
            end else if (rx_start) begin
                // First bit of the frame, bit count starts at one
                rx_busy_ff <= 1'b1;
                rx_cnt_ff  <= 5'h01;
                rx_sh_ff   <= {15'h0000, sd_sync_ff[1]};
            end else if (rx_busy_ff && ck_rise) begin
                rx_sh_ff   <= rx_next;
                rx_cnt_ff  <= rx_cnt_ff + 5'h01;
                if (rx_cnt_ff == frame_bits) begin
                    rx_busy_ff <= 1'b0;
                end
            end
        end
    end
    assign transfer_ongoing_flag = rx_busy_ff | tx_frame_busy;
    // Clear on CRC enable written to one or on peripheral reset
    assign ap_take = hsel && hready && htrans[1];
    assign wr_ctrl = ap_wr_ff && (ap_addr_ff == `SAC_OFS_CTRL);
    assign crc_clr = peripheral_reset_bit || (wr_ctrl && hwdata[`SAC_CTRL_CRC_CHECK_ENABLE]);
    // CRC accumulators, one step per bit
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_crc_value <= 16'h0000;
            tx_crc_value <= 16'h0000;
        end else if (ce) begin
            if (crc_clr) begin
                rx_crc_value <= 16'h0000;
                tx_crc_value <= 16'h0000;
            end else if (crc_check_enable) begin
                // The start bit counts as well, or the sum would miss it
                if (rx_start || (rx_busy_ff && ck_rise)) begin
                    rx_crc_value <= sac_crc_step(rx_crc_value, poly_ff, sd_sync_ff[1], frame16);
                end
                if (tx_bit_valid) begin
                    // Bit arrives in wire order, so bit order shapes the result
                    tx_crc_value <= sac_crc_step(tx_crc_value, poly_ff, tx_bit_value, frame16);
                end
            end
        end
    end
    // Pin drive: master drives clock and word select, transmitter drives data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sd_out_ff       <= 1'b0;
            audio_ck_out_ff <= 1'b0;
            audio_ck_oe_ff  <= 1'b0;
            ws_oe_ff        <= 1'b0;
            sd_oe_ff        <= 1'b0;
        end else if (ce) begin
            audio_ck_out_ff <= idle_clock_level & aud_active;
            audio_ck_oe_ff  <= is_master;
            ws_oe_ff        <= is_master;
            sd_oe_ff        <= port_enable & ~is_rx_mode;
            sd_out_ff       <= tx_bit_valid ? tx_bit_value : sd_out_ff;
        end
    end
    // AHB address phase capture; writes complete in data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff   <= 1'b0;
            ap_addr_ff <= 12'h000;
        end else if (ce) begin
            ap_wr_ff   <= ap_take & hwrite;
            ap_addr_ff <= {haddr[11:2], 2'b00};
        end
    end
    assign aud_wr_data = hwdata & `SAC_AUD_MASK;
    // Register writes; reserved bits masked off
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= 32'h00000000;
            poly_ff <= `SAC_POLY_RST;
            aud_ff  <= 12'h000;
        end else if (ce && ap_wr_ff) begin
            case (ap_addr_ff)
                `SAC_OFS_CTRL:  ctrl_ff <= hwdata & `SAC_CTRL_MASK;
                `SAC_OFS_POLY:  poly_ff <= hwdata[15:0];
                `SAC_OFS_AUDIO: aud_ff  <= aud_wr_data[11:0];
                default:        ctrl_ff <= ctrl_ff;
            endcase
        end
    end
    // Read mux; half-word reads of CRC get the same low lanes
    always @* begin
        case ({haddr[11:2], 2'b00})
            `SAC_OFS_CTRL:   rd_mux = ctrl_ff;
            `SAC_OFS_POLY:   rd_mux = {16'h0000, poly_ff};
            `SAC_OFS_RXCRC:  rd_mux = {16'h0000, rx_crc_value};
            `SAC_OFS_TXCRC:  rd_mux = {16'h0000, tx_crc_value};
            `SAC_OFS_AUDIO:  rd_mux = {20'h00000, aud_ff};
            `SAC_OFS_STAT:   rd_mux = {29'h0, fifo_out_valid, channel_slot_length, transfer_ongoing_flag};
            `SAC_OFS_RXDATA: rd_mux = {16'h0000, fifo_out_data};
            default:         rd_mux = 32'h00000000;
        endcase
    end
    assign fifo_pop = ce && ap_take && !hwrite && ({haddr[11:2], 2'b00} == `SAC_OFS_RXDATA);
    // Read data registered at the address phase edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (ce && ap_take && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end
    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // Received frames buffered for software
    sac_fifo #(
        .WIDTH (16),
        .DEPTH (`SAC_FIFO_DEPTH),
        .AW    (`SAC_FIFO_AW)
    ) u_rx_fifo (
        .clk       (hclk),
        .rst_n     (hresetn),
        .ce        (ce),
        .flush     (peripheral_reset_bit),
        .in_data   (rx_next),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );
endmodule
`default_nettype wire

// ---- testbench/sac_top_sva.sv ----
// Port checker for the serial CRC and audio control block
`timescale 1ns/100ps
`default_nettype none
module sac_top_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        audio_ck_oe_ff,
    input wire logic        ws_oe_ff,
    input wire logic        sd_oe_ff
);
    logic        wr_ff;   // Write data phase pending
    logic [11:0] wa_ff;   // Address of that write
    logic [11:0] aud_ff;  // Shadow of the audio control register
    wire         take = hsel & hready & htrans[1] & ce;
    wire         rd_take = take & ~hwrite;
    // Shadow follows bus writes so pin enables can be tied to the mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            wa_ff <= 12'h000;
            aud_ff <= 12'h000;
        end else if (ce) begin
            wr_ff <= take & hwrite;
            wa_ff <= haddr;
            if (wr_ff && wa_ff == 12'h01c) begin
                aud_ff <= hwdata[11:0] & 12'hfbf;
            end
        end
    end
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_high:
        assert property (hreadyout) else $error("hreadyout dropped");
    a_resp_okay:
        assert property (!hresp) else $error("error response seen");
    a_rdata_holds:
        assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved without a read");
    a_upper_zero:
        assert property (hrdata[31:16] == 16'h0000) else $error("upper read lanes not zero");
    a_spi_quiet:
        assert property ((!aud_ff[11])[*3] |-> !audio_ck_oe_ff && !ws_oe_ff) else $error("audio pins driven in SPI mode");
    a_slave_no_clock:
        assert property ((aud_ff[11] && aud_ff[10] && !aud_ff[9])[*3] |-> !audio_ck_oe_ff && !ws_oe_ff)
            else $error("slave drives clock or word select");
    a_master_drives_clock:
        assert property ((aud_ff[11] && aud_ff[10] && aud_ff[9])[*3] |-> audio_ck_oe_ff && ws_oe_ff)
            else $error("master leaves clock or word select undriven");
    a_rx_no_data:
        assert property ((aud_ff[11] && aud_ff[8])[*3] |-> !sd_oe_ff) else $error("receiver drives data line");
endmodule
bind sac_top sac_top_sva chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .audio_ck_oe_ff, .ws_oe_ff, .sd_oe_ff);
`default_nettype wire

// ---- testbench/sac_link_model.sv ----
// Far-side serial peer that clocks frames into the block
`timescale 1ns/100ps
`default_nettype none
module sac_link_model (
    output logic link_ck,
    output logic link_sd,
    output logic link_ws
);
    // Clock idles low and stands still between frames
    initial begin
        link_ck = 1'b0;
        link_sd = 1'b0;
        link_ws = 1'b0;
    end
    // Bits MSB first, data changes while the clock is low
    task automatic send_frame(input logic [15:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            link_sd = d[i];
            #62.5 link_ck = 1'b1;
            #62.5 link_ck = 1'b0;
        end
        link_sd = ~d[0];  // Released line must not look like the last bit
    endtask
endmodule
`default_nettype wire

// ---- testbench/spi_crc_and_i2s_config_test.sv ----
// Bench for the serial CRC and audio control block
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.vh"
module spi_crc_and_i2s_config_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd, v;
    logic        peripheral_reset_bit, audio_bit_clock, link_sd_in, link_ws_in;
    logic        tx_bit_valid, tx_bit_value, tx_frame_busy;
    logic        audio_ck_out_ff, audio_ck_oe_ff, ws_oe_ff, sd_oe_ff;
    logic [15:0] crc_a;   // Expected CRC worked out here
    int          failures, tests_run;
    // Bus hready is the lone slave's hreadyout; clock enable kept on
    sac_top uut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .peripheral_reset_bit, .audio_bit_clock,
        .link_sd_in, .link_ws_in, .tx_bit_valid, .tx_bit_value, .tx_frame_busy, .sd_out_ff(),
        .audio_ck_out_ff, .audio_ck_oe_ff, .ws_oe_ff, .sd_oe_ff);
    sac_link_model link (.link_ck(audio_bit_clock), .link_sd(link_sd_in), .link_ws(link_ws_in));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // One CRC bit step, MSB-first shift, 8-bit form kept in the low byte
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic w);
        logic fb;
        fb = (w ? c[15] : c[7]) ^ b;
        crc_step = (c << 1) ^ (fb ? `SAC_POLY_RST : 16'h0000);
        if (!w) crc_step[15:8] = 8'h00;
    endfunction
    // Single AHB-Lite transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, 3'h2);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, 3'h2);
        chk(n, e, rd);
    endtask
    // Pulses one transmitted bit per two cycles, tracking the CRC
    task automatic txbits(input logic [15:0] d, input int n, input logic lsb, input logic w);
        logic b;
        for (int i = 0; i < n; i++) begin
            b = lsb ? d[i] : d[n - 1 - i];
            crc_a = crc_step(crc_a, b, w);
            @(posedge hclk);
            tx_bit_valid <= 1'b1;
            tx_bit_value <= b;
            @(posedge hclk);
            tx_bit_valid <= 1'b0;
        end
    endtask
    task automatic final_report;
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        failures++;
        final_report();
    end
    initial begin
        {hresetn, hsel, hwrite, peripheral_reset_bit, tx_bit_valid, tx_bit_value, tx_frame_busy} = 7'h0;
        {haddr, htrans, hsize, hwdata} = 49'h0;
        failures = 0;
        tests_run = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("tx crc reset value", `SAC_OFS_TXCRC, 32'h0);
        rdc("audio reset value", `SAC_OFS_AUDIO, 32'h0);
        wr(`SAC_OFS_AUDIO, 32'hfffffbff);
        rdc("audio reserved", `SAC_OFS_AUDIO, 32'h00000bbf);
        // Every code of each field, written while disabled, slot >= sample
        for (int k = 0; k < 4; k++) begin
            v = 32'h800 | k << 8 | (k & 1) << 7 | k << 4 | (k & 1) << 3 | (k % 3) << 1 | (k % 3 != 0);
            wr(`SAC_OFS_AUDIO, v);
            rdc("audio fields", `SAC_OFS_AUDIO, v);
        end
        // Pin drive per operation mode, idle clock high when mastering
        for (int m = 0; m < 4; m++) begin
            wr(`SAC_OFS_AUDIO, 32'h808 | m << 8);
            wr(`SAC_OFS_AUDIO, 32'hc08 | m << 8);
            rdc("audio enabled", `SAC_OFS_AUDIO, 32'hc08 | m << 8);
            chk("clock drive", m[1], audio_ck_oe_ff);
            chk("word select drive", m[1], ws_oe_ff);
            chk("data drive", !m[0], sd_oe_ff);
            if (m[1]) chk("idle clock", 1, audio_ck_out_ff);
            wr(`SAC_OFS_AUDIO, 32'h808 | m << 8);
        end
        wr(`SAC_OFS_AUDIO, 32'h0);
        wr(`SAC_OFS_AUDIO, 32'h608);
        rdc("spi mode audio", `SAC_OFS_AUDIO, 32'h608);
        chk("spi mode pins", 0, {audio_ck_oe_ff, ws_oe_ff, sd_oe_ff});
        wr(`SAC_OFS_AUDIO, 32'h0);
        // Transmit CRC: partial, whole, half-word, clear, bit order, 16-bit
        wr(`SAC_OFS_CTRL, 32'h1);
        crc_a = 16'h0;
        txbits(16'h000a, 4, 1'b0, 1'b0);
        rdc("tx crc partial", `SAC_OFS_TXCRC, crc_a);
        txbits(16'h0005, 4, 1'b0, 1'b0);
        rdc("tx crc byte", `SAC_OFS_TXCRC, crc_a);
        ahb(1'b0, `SAC_OFS_TXCRC, 32'h0, 3'h1);
        chk("tx crc half", crc_a, rd[15:0]);
        wr(`SAC_OFS_CTRL, 32'h3);
        rdc("tx crc cleared", `SAC_OFS_TXCRC, 32'h0);
        crc_a = 16'h0;
        txbits(16'h00a5, 8, 1'b1, 1'b0);
        rdc("tx crc lsb first", `SAC_OFS_TXCRC, crc_a);
        wr(`SAC_OFS_CTRL, 32'h5);
        crc_a = 16'h0;
        txbits(16'h1234, 16, 1'b0, 1'b1);
        rdc("tx crc wide", `SAC_OFS_TXCRC, crc_a);
        // Receive path with a pause mid-frame, then peripheral reset
        wr(`SAC_OFS_CTRL, 32'h11);
        tx_frame_busy <= 1'b1;
        rdc("busy flag", `SAC_OFS_STAT, 32'h1);
        tx_frame_busy <= 1'b0;
        v = 32'ha5;
        crc_a = 16'h0;
        for (int i = 7; i >= 4; i--) crc_a = crc_step(crc_a, v[i], 1'b0);
        link.send_frame(16'h000a, 4);
        rdc("rx crc partial", `SAC_OFS_RXCRC, crc_a);
        for (int i = 3; i >= 0; i--) crc_a = crc_step(crc_a, v[i], 1'b0);
        link.send_frame(16'h0005, 4);
        rdc("rx crc byte", `SAC_OFS_RXCRC, crc_a);
        rdc("idle status", `SAC_OFS_STAT, 32'h4);
        rdc("rx data", `SAC_OFS_RXDATA, 32'ha5);
        peripheral_reset_bit <= 1'b1;
        @(posedge hclk);
        peripheral_reset_bit <= 1'b0;
        rdc("rx crc after reset", `SAC_OFS_RXCRC, 32'h0);
        rdc("tx crc after reset", `SAC_OFS_TXCRC, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
